// file: pkg/pfrt_cfg.svh
// constants for the power-fail stop and fault retry controller
`ifndef PFRT_CFG_SVH
`define PFRT_CFG_SVH

// register byte offsets
`define PFRT_OFF_PFSEL 8'h00
`define PFRT_OFF_COAST 8'h04
`define PFRT_OFF_RCLASS 8'h08
`define PFRT_OFF_RLIMIT 8'h0C
`define PFRT_OFF_RWAIT 8'h10
`define PFRT_OFF_RSUCC 8'h14
`define PFRT_OFF_OUTFN0 8'h18
`define PFRT_OFF_STATUS 8'h24

// reset values
`define PFRT_RST_PFSEL 2'h0
`define PFRT_RST_COAST 16'h270F
`define PFRT_RST_RCLASS 3'h0
`define PFRT_RST_RLIMIT 8'h00
`define PFRT_RST_RWAIT 12'h00A
`define PFRT_RST_OUTFN 8'h00

// encodings and limits
`define PFRT_COAST_OFF 16'h270F
`define PFRT_SEL_COAST 2'h0
`define PFRT_SEL_STOP 2'h1
`define PFRT_SEL_REACCEL 2'h2
`define PFRT_CLASS_MAX 3'h5
`define PFRT_LIMIT_MAX 8'h0A
`define PFRT_LIMIT_OFS 8'h64
`define PFRT_WAIT_MIN 12'h001
`define PFRT_WAIT_MAX 12'hE10
`define PFRT_SUCC_MULT 3'h4
`define PFRT_FN_PFD_POS 8'h2E
`define PFRT_FN_PFD_NEG 8'h92
`define PFRT_FN_RTY_POS 8'h40
`define PFRT_FN_RTY_NEG 8'hA4

// timing: one wait tick is 0.1 s
`define PFRT_TICK_US 100000
`define PFRT_CLK_MHZ 100
`define PFRT_NUM_TERM 3

`endif

// file: pkg/pfrt_pkg.sv
// types for the power-fail stop and fault retry controller
package pfrt_pkg;

  // drive sequencing states
  typedef enum logic [3:0] {
    PFRT_STOP, PFRT_RUN, PFRT_NDECEL, PFRT_PF_DECEL, PFRT_PF_STOPPED,
    PFRT_COAST_WAIT, PFRT_RETRY_WAIT, PFRT_LATCHED
  } pfrt_drv_t;

  // command to the frequency control
  typedef enum logic [2:0] {
    PFRT_M_IDLE, PFRT_M_RUN, PFRT_M_DECEL, PFRT_M_HOLD_BUS, PFRT_M_COAST
  } pfrt_mode_t;

  // fault codes reported by the trip logic
  typedef enum logic [4:0] {
    FLT_OC_ACCEL, FLT_OC_CONST, FLT_OC_DECEL, FLT_OV_ACCEL, FLT_OV_CONST,
    FLT_OV_DECEL, FLT_MOTOR_THERM, FLT_TRANS_THERM, FLT_BRAKE_TR, FLT_GROUND,
    FLT_USB, FLT_EXT_THERM, FLT_STALL, FLT_OPT, FLT_COMM_OPT, FLT_PARAM_STORE,
    FLT_CPU0, FLT_CPU1, FLT_CPU2, FLT_CPU3, FLT_IN_PHASE, FLT_OTHER
  } pfrt_fault_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pfrt_bus_t;

  // trip event from the protective logic
  typedef struct packed {
    logic valid;
    pfrt_fault_t code;
  } pfrt_trip_t;

  // outputs toward the frequency control
  typedef struct packed {
    pfrt_mode_t mode;
    logic restart;
    logic auto_restart;
  } pfrt_freq_t;

  // whole module state
  typedef struct packed {
    pfrt_drv_t drv;
    logic [1:0] pfsel;
    logic [15:0] coast;
    logic [2:0] rclass;
    logic [7:0] rlimit;
    logic [11:0] rwait;
    logic [15:0] succ;
    logic [2:0][7:0] outfn;
    logic start_block;
    logic [3:0] fail_cnt;
    logic excess;
    logic [23:0] tick_cnt;
    logic [11:0] wait_cnt;
    logic watch_on;
    logic [14:0] watch_cnt;
    logic fault_out;
    logic [2:0] term;
    pfrt_freq_t freq;
    logic [31:0] rd_data;
  } pfrt_state_t;

endpackage

// file: rtl/pfrt_ctrl.sv
// power-fail stop selection and fault retry sequencer
//
// Design decisions made here: the plain strobed port and the address map.
`include "pfrt_cfg.svh"

module pfrt_ctrl import pfrt_pkg::*; #(
  parameter int TICK_CYCLES = `PFRT_TICK_US * `PFRT_CLK_MHZ,
  parameter int NUM_TERM = `PFRT_NUM_TERM
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input pfrt_bus_t bus,
  output logic [31:0] rd_data,
  // run controller
  input wire logic forward_start_cmd,
  input wire logic reverse_start_cmd,
  input wire logic fault_reset,
  // power stage and frequency control
  input wire logic power_fail,
  input wire logic at_zero_freq,
  input pfrt_trip_t trip,
  output pfrt_freq_t freq,
  // fault and flag outputs
  output logic trip_out,
  output logic fault_out,
  output logic retry_excess_fault,
  output logic power_fail_decel_flag,
  output logic retry_active_flag,
  output logic [NUM_TERM-1:0] term_out
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << 24)) begin
      $error("pfrt_ctrl: TICK_CYCLES out of range");
    end
    if (NUM_TERM < 1 || NUM_TERM > 3) begin
      $error("pfrt_ctrl: NUM_TERM must be 1 to 3");
    end
  end

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // fault class table
  function automatic logic class_hit(input logic [2:0] cls, input pfrt_fault_t f);
    logic oc;
    logic ov;
    logic therm;
    oc = (f == FLT_OC_ACCEL) || (f == FLT_OC_CONST) || (f == FLT_OC_DECEL);
    ov = (f == FLT_OV_ACCEL) || (f == FLT_OV_CONST) || (f == FLT_OV_DECEL);
    therm = (f == FLT_MOTOR_THERM) || (f == FLT_TRANS_THERM) || (f == FLT_EXT_THERM);
    unique case (cls)
      3'h0: class_hit = (f != FLT_OTHER);
      3'h1: class_hit = oc;
      3'h2: class_hit = ov;
      3'h3: class_hit = oc || ov;
      3'h4: class_hit = (f != FLT_OTHER) && !therm;
      3'h5: class_hit = (f == FLT_OC_ACCEL) || (f == FLT_OC_DECEL);
      default: class_hit = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  pfrt_state_t cur;
  pfrt_state_t next_s;

  logic start;
  logic auto_rst_en;
  logic [7:0] n_retry;
  logic fault_visible;
  logic selected;
  logic [4:0] fails;
  logic pf_flag;
  logic rty_flag;
  logic [14:0] watch_lim;

  // decoded settings
  always_comb begin
    start = forward_start_cmd | reverse_start_cmd;
    auto_rst_en = (cur.coast != `PFRT_COAST_OFF);
    fault_visible = (cur.rlimit > `PFRT_LIMIT_MAX);
    n_retry = fault_visible ? (cur.rlimit - `PFRT_LIMIT_OFS) : cur.rlimit;
    selected = (n_retry != 8'h00) && class_hit(cur.rclass, trip.code);
    fails = {1'b0, cur.fail_cnt} + 5'h01;
    watch_lim = 15'(cur.rwait) * 15'(`PFRT_SUCC_MULT);
    pf_flag = (cur.drv == PFRT_PF_DECEL) || (cur.drv == PFRT_PF_STOPPED);
    rty_flag = (cur.drv == PFRT_RETRY_WAIT);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic pfn;
    logic rtn;
    pfn = 1'b0;
    rtn = 1'b0;
    next_s = cur;
    next_s.freq.restart = 1'b0;
    next_s.rd_data = 32'h0000_0000;

    // 0.1 s timebase, running only while timing something
    if (rty_flag || cur.watch_on) begin
      if (cur.tick_cnt == TICK_LAST) begin
        next_s.tick_cnt = 24'h00_0000;
      end else begin
        next_s.tick_cnt = cur.tick_cnt + 24'h00_0001;
      end
    end else begin
      next_s.tick_cnt = 24'h00_0000;
    end

    // a start seen low releases the power-up or stop interlock
    if (!start) begin
      next_s.start_block = 1'b0;
    end

    // success watch after a retry start
    if (cur.watch_on && cur.tick_cnt == TICK_LAST) begin
      // ticks done is watch_cnt + 1, so >= means strictly more than four waits
      if (cur.watch_cnt >= watch_lim) begin
        next_s.watch_on = 1'b0;
        next_s.fail_cnt = 4'h0;
        next_s.succ = cur.succ + 16'h0001;
      end else begin
        next_s.watch_cnt = cur.watch_cnt + 15'h0001;
      end
    end

    // drive sequencing
    unique case (cur.drv)
      PFRT_STOP: begin
        next_s.freq.mode = PFRT_M_IDLE; // power failure not looked at
        // interlock only binds with stop-on-failure selected
        if (start && !(cur.start_block && cur.pfsel == `PFRT_SEL_STOP)) begin
          next_s.drv = PFRT_RUN;
          next_s.freq.mode = PFRT_M_RUN;
        end
      end
      PFRT_RUN, PFRT_NDECEL: begin
        // start already low means normal decel; avoids bouncing into failure decel
        if (power_fail && start) begin
          if (auto_rst_en) begin
            next_s.drv = PFRT_COAST_WAIT;
            next_s.freq.mode = PFRT_M_COAST;
          end else if (cur.pfsel == `PFRT_SEL_COAST) begin
            next_s.drv = PFRT_STOP;
            next_s.freq.mode = PFRT_M_COAST;
          end else begin
            next_s.drv = PFRT_PF_DECEL;
            next_s.freq.mode = PFRT_M_HOLD_BUS;
          end
        end else if (!start) begin
          next_s.drv = PFRT_NDECEL;
          next_s.freq.mode = PFRT_M_DECEL;
          if (at_zero_freq) begin
            next_s.drv = PFRT_STOP;
            next_s.freq.mode = PFRT_M_IDLE;
          end
        end else begin
          next_s.drv = PFRT_RUN;
          next_s.freq.mode = PFRT_M_RUN;
        end
      end
      PFRT_PF_DECEL: begin
        if (cur.pfsel == `PFRT_SEL_REACCEL && !start) begin
          next_s.drv = PFRT_NDECEL;
          next_s.freq.mode = PFRT_M_DECEL;
        end else if (cur.pfsel == `PFRT_SEL_REACCEL && !power_fail) begin
          next_s.drv = PFRT_RUN;
          next_s.freq.mode = PFRT_M_RUN;
        end else if (at_zero_freq) begin
          next_s.drv = PFRT_PF_STOPPED;
          next_s.freq.mode = PFRT_M_IDLE;
          next_s.start_block = 1'b1;
        end
      end
      PFRT_PF_STOPPED: begin
        // reaccel resumes with start held once power returns; with stop selected a fresh start edge is needed
        if (cur.pfsel == `PFRT_SEL_REACCEL && !power_fail && start) begin
          next_s.drv = PFRT_RUN;
          next_s.freq.mode = PFRT_M_RUN;
        end else if (!start) begin
          next_s.drv = PFRT_STOP;
        end
      end
      PFRT_COAST_WAIT: begin
        if (!power_fail) begin
          if (start) begin
            next_s.drv = PFRT_RUN;
            next_s.freq.mode = PFRT_M_RUN;
            next_s.freq.restart = 1'b1;
            next_s.freq.auto_restart = 1'b1;
          end else begin
            next_s.drv = PFRT_STOP;
            next_s.freq.mode = PFRT_M_IDLE;
          end
        end
      end
      PFRT_RETRY_WAIT: begin
        next_s.freq.mode = PFRT_M_COAST; // output stays shut off while tripped
        if (cur.tick_cnt == TICK_LAST) begin
          if (cur.wait_cnt <= 12'h001) begin
            // wait over: clear fault and restart from starting frequency
            next_s.drv = PFRT_RUN;
            next_s.freq.mode = PFRT_M_RUN;
            next_s.freq.restart = 1'b1;
            next_s.freq.auto_restart = auto_rst_en;
            next_s.fault_out = 1'b0;
            next_s.watch_on = 1'b1;
            next_s.watch_cnt = 15'h0000;
          end else begin
            next_s.wait_cnt = cur.wait_cnt - 12'h001;
          end
        end
      end
      PFRT_LATCHED: begin
        next_s.freq.mode = PFRT_M_IDLE;
        if (fault_reset) begin
          next_s.drv = PFRT_STOP;
          next_s.fault_out = 1'b0;
          next_s.excess = 1'b0;
          next_s.fail_cnt = 4'h0;
          next_s.watch_on = 1'b0;
        end
      end
    endcase

    // a trip overrides any sequencing; latched trips wait for reset
    if (trip.valid && cur.drv != PFRT_LATCHED) begin
      next_s.freq.mode = PFRT_M_COAST;
      next_s.freq.restart = 1'b0;
      next_s.freq.auto_restart = 1'b0;
      next_s.watch_on = 1'b0;
      next_s.tick_cnt = 24'h00_0000;
      if (!selected) begin
        next_s.drv = PFRT_LATCHED;
        next_s.fault_out = 1'b1;
      end else if ((rty_flag || cur.watch_on) && fails > 5'(n_retry)) begin
        next_s.drv = PFRT_LATCHED;
        next_s.excess = 1'b1;
        next_s.fault_out = 1'b1;
      end else begin
        if (rty_flag || cur.watch_on) begin
          next_s.fail_cnt = fails[3:0];
        end
        next_s.drv = PFRT_RETRY_WAIT;
        next_s.wait_cnt = cur.rwait;
        next_s.fault_out = fault_visible;
      end
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `PFRT_OFF_PFSEL: begin
          if (bus.wdata[1:0] <= `PFRT_SEL_REACCEL) begin
            next_s.pfsel = bus.wdata[1:0];
          end
        end
        `PFRT_OFF_COAST: next_s.coast = bus.wdata[15:0];
        `PFRT_OFF_RCLASS: begin
          if (bus.wdata[2:0] <= `PFRT_CLASS_MAX) begin
            next_s.rclass = bus.wdata[2:0];
          end
        end
        `PFRT_OFF_RLIMIT: begin
          if (bus.wdata[7:0] <= `PFRT_LIMIT_MAX || (bus.wdata[7:0] > `PFRT_LIMIT_OFS
              && bus.wdata[7:0] <= `PFRT_LIMIT_OFS + `PFRT_LIMIT_MAX)) begin
            next_s.rlimit = bus.wdata[7:0];
          end
        end
        `PFRT_OFF_RWAIT: begin
          if (bus.wdata[11:0] >= `PFRT_WAIT_MIN && bus.wdata[11:0] <= `PFRT_WAIT_MAX) begin
            next_s.rwait = bus.wdata[11:0];
          end
        end
        `PFRT_OFF_RSUCC: begin
          // clear then the same-cycle success still counts
          if (bus.wdata == 32'h0000_0000) begin
            next_s.succ = (next_s.succ != cur.succ) ? 16'h0001 : 16'h0000;
          end
        end
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (bus.addr == `PFRT_OFF_OUTFN0 + 8'(4 * i)) begin
              next_s.outfn[i] = bus.wdata[7:0];
            end
          end
        end
      endcase
    end

    // register reads, answered next cycle
    if (bus.rd) begin
      unique case (bus.addr)
        `PFRT_OFF_PFSEL: next_s.rd_data = {30'h0, cur.pfsel};
        `PFRT_OFF_COAST: next_s.rd_data = {16'h0000, cur.coast};
        `PFRT_OFF_RCLASS: next_s.rd_data = {29'h0, cur.rclass};
        `PFRT_OFF_RLIMIT: next_s.rd_data = {24'h00_0000, cur.rlimit};
        `PFRT_OFF_RWAIT: next_s.rd_data = {20'h0_0000, cur.rwait};
        `PFRT_OFF_RSUCC: next_s.rd_data = {16'h0000, cur.succ};
        `PFRT_OFF_STATUS: begin
          next_s.rd_data = {16'h0000, cur.fail_cnt, cur.drv, 3'h0, cur.watch_on,
                            cur.excess, cur.fault_out, rty_flag, pf_flag};
        end
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (bus.addr == `PFRT_OFF_OUTFN0 + 8'(4 * i)) begin
              next_s.rd_data = {24'h00_0000, cur.outfn[i]};
            end
          end
        end
      endcase
    end

    // terminal routing from the next flag values
    pfn = (next_s.drv == PFRT_PF_DECEL) || (next_s.drv == PFRT_PF_STOPPED);
    rtn = (next_s.drv == PFRT_RETRY_WAIT);
    for (int i = 0; i < NUM_TERM; i++) begin
      unique case (next_s.outfn[i])
        `PFRT_FN_PFD_POS: next_s.term[i] = pfn;
        `PFRT_FN_PFD_NEG: next_s.term[i] = !pfn;
        `PFRT_FN_RTY_POS: next_s.term[i] = rtn;
        `PFRT_FN_RTY_NEG: next_s.term[i] = !rtn;
        default: next_s.term[i] = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.drv <= PFRT_STOP;
      cur.pfsel <= `PFRT_RST_PFSEL;
      cur.coast <= `PFRT_RST_COAST;
      cur.rclass <= `PFRT_RST_RCLASS;
      cur.rlimit <= `PFRT_RST_RLIMIT;
      cur.rwait <= `PFRT_RST_RWAIT;
      cur.outfn <= {3{`PFRT_RST_OUTFN}};
      cur.start_block <= 1'b1; // start held at power-up must cycle when stop-on-failure is selected
      cur.freq.mode <= PFRT_M_IDLE;
    end else if (ce) begin
      cur <= next_s;
    end
  end

  // outputs
  assign rd_data = cur.rd_data;
  assign freq = cur.freq;
  assign trip_out = (cur.drv == PFRT_RETRY_WAIT) || (cur.drv == PFRT_LATCHED);
  assign fault_out = cur.fault_out;
  assign retry_excess_fault = cur.excess;
  assign power_fail_decel_flag = pf_flag;
  assign retry_active_flag = rty_flag;
  assign term_out = cur.term[NUM_TERM-1:0];

endmodule // pfrt_ctrl

// file: verification/pfrt_ctrl_sva.sv
// port checks for the power-fail stop and fault retry controller
module pfrt_ctrl_chk import pfrt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // inputs seen
  input wire pfrt_bus_t bus,
  input wire logic forward_start_cmd,
  input wire logic reverse_start_cmd,
  input wire logic fault_reset,
  input wire logic power_fail,
  input wire pfrt_trip_t trip,
  // outputs watched
  input wire logic [31:0] rd_data,
  input wire pfrt_freq_t freq,
  input wire logic trip_out,
  input wire logic fault_out,
  input wire logic retry_excess_fault,
  input wire logic power_fail_decel_flag,
  input wire logic retry_active_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  property p_pf_hold;
    ce && $rose(power_fail_decel_flag) |-> freq.mode == PFRT_M_HOLD_BUS;
  endproperty
  a_pf_hold: assert property (p_pf_hold)
    else $error("power-fail decel not holding the bus");
  // flag must survive while power is still out and start held
  property p_pf_stays;
    ce && power_fail_decel_flag && power_fail && (forward_start_cmd || reverse_start_cmd)
      && !trip.valid && !fault_reset |=> power_fail_decel_flag;
  endproperty
  a_pf_stays: assert property (p_pf_stays)
    else $error("power-fail flag dropped during outage");
  property p_no_pf_idle;
    ce && (trip_out || freq.mode == PFRT_M_IDLE) && !power_fail_decel_flag
      |=> !power_fail_decel_flag;
  endproperty
  a_no_pf_idle: assert property (p_no_pf_idle)
    else $error("power-fail stop entered from stop or trip");
  property p_retry_coast;
    retry_active_flag |-> trip_out && freq.mode == PFRT_M_COAST;
  endproperty
  a_retry_coast: assert property (p_retry_coast)
    else $error("retry flag without trip and coast");
  property p_restart_pulse;
    ce && freq.restart |=> !freq.restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse longer than one cycle");
  property p_restart_run;
    $rose(freq.restart) |-> !retry_active_flag && (freq.auto_restart || freq.mode == PFRT_M_RUN);
  endproperty
  a_restart_run: assert property (p_restart_run)
    else $error("restart without run");
  // shortest legal wait is one tick, four cycles in simulation
  property p_wait_min;
    $rose(retry_active_flag) ##0 (ce && !trip.valid && !fault_reset)[*3] |=> retry_active_flag;
  endproperty
  a_wait_min: assert property (p_wait_min)
    else $error("retry wait shorter than one tick");
  property p_excess;
    retry_excess_fault |-> trip_out && !retry_active_flag;
  endproperty
  a_excess: assert property (p_excess)
    else $error("retry excess without trip");
  property p_unselected;
    ce && trip.valid && trip.code == FLT_OTHER && !fault_reset
      |=> trip_out && fault_out && !retry_active_flag;
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("unselected fault not latched");
  property p_rd_idle;
    ce && !bus.rd |=> rd_data == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the answer cycle");
endmodule // pfrt_ctrl_chk

bind pfrt_ctrl pfrt_ctrl_chk i_pfrt_ctrl_chk (.clk, .rst_n, .ce, .bus, .forward_start_cmd,
  .reverse_start_cmd, .fault_reset, .power_fail, .trip, .rd_data, .freq, .trip_out, .fault_out,
  .retry_excess_fault, .power_fail_decel_flag, .retry_active_flag);

// file: verification/pfrt_drive_model.sv
// motor and power stage model: ramps output to zero while decelerating
module pfrt_drive_model import pfrt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stage control
  input wire logic slow,
  input wire pfrt_freq_t freq,
  output logic at_zero_freq
);
  timeunit 1ns;
  timeprecision 100ps;
  int ramp;
  // slow ramp leaves room to restore power mid-decel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp <= 0;
      at_zero_freq <= 1'b1;
    end else if (freq.mode == PFRT_M_RUN) begin
      ramp <= slow ? 40 : 3;
      at_zero_freq <= 1'b0;
    end else if (ramp > 0) begin
      ramp <= ramp - 1;
    end else begin
      at_zero_freq <= 1'b1;
    end
  end
endmodule // pfrt_drive_model

// file: verification/testbench.sv
// self-checking bench for the power-fail stop and fault retry controller
module testbench import pfrt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, ce, fwd, rev, fault_reset, power_fail, at_zero, slow;
  logic trip_out, fault_out, exc, pfd, rty;
  logic [31:0] rd_data;
  logic [2:0] term_out;
  pfrt_bus_t bus;
  pfrt_trip_t trip;
  pfrt_freq_t freq;
  int failures, samples_checked, seed, i, j, n, v;
  logic [31:0] rstv [8] = '{0, 32'h0000_270F, 0, 0, 32'h0000_000A, 0, 0, 0};

  pfrt_ctrl #(.TICK_CYCLES(4)) i_pfrt_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rd_data(rd_data), .forward_start_cmd(fwd), .reverse_start_cmd(rev),
    .fault_reset(fault_reset), .power_fail(power_fail), .at_zero_freq(at_zero), .trip(trip),
    .freq(freq), .trip_out(trip_out), .fault_out(fault_out), .retry_excess_fault(exc),
    .power_fail_decel_flag(pfd), .retry_active_flag(rty), .term_out(term_out));
  pfrt_drive_model i_pfrt_drive_model (.clk(clk), .rst_n(rst_n), .slow(slow), .freq(freq),
    .at_zero_freq(at_zero));

  ////////////////////////////////////////////////////////////////////////
  task results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(what, e, rd_data);
  endtask
  task trip_pulse(input pfrt_fault_t f);
    @(posedge clk);
    trip <= '{1'b1, f};
    @(posedge clk);
    trip.valid <= 1'b0;
  endtask
  task clear_fault();
    @(posedge clk);
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return pfd === 1'b1;
      1: return pfd === 1'b0;
      2: return freq.restart === 1'b1;
      3: return freq.mode === PFRT_M_RUN;
      default: return freq.mode === PFRT_M_DECEL;
    endcase
  endfunction
  // bounded wait; a timeout ends the run
  task waitc(input int k, input int lim);
    n = 0;
    #1;
    while (!cond(k)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        failures++;
        $display("BAD wait %0d expected within %0d seen timeout", k, lim);
        results();
      end
    end
  endtask
  // faults each retry class should restart from
  function automatic logic picked(input int c, input pfrt_fault_t f);
    logic oc, ov, th;
    oc = f inside {FLT_OC_ACCEL, FLT_OC_CONST, FLT_OC_DECEL};
    ov = f inside {FLT_OV_ACCEL, FLT_OV_CONST, FLT_OV_DECEL};
    th = f inside {FLT_MOTOR_THERM, FLT_TRANS_THERM, FLT_EXT_THERM};
    case (c)
      0: return f != FLT_OTHER;
      1: return oc;
      2: return ov;
      3: return oc | ov;
      4: return f != FLT_OTHER && !th;
      default: return f inside {FLT_OC_ACCEL, FLT_OC_DECEL};
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, rev, fault_reset, power_fail, slow} = '0;
    {ce, fwd} = 2'h3;
    bus = '0;
    trip = '0;
    failures = 0;
    samples_checked = 0;
    seed = 76938;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped read, refused and random writes
    for (i = 0; i < 8; i++) rdc("reset value", 8'(4 * i), rstv[i]);
    rdc("unmapped", 8'h30, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      v = $unsigned($random(seed)) % 10 + 1 + (i[0] ? 100 : 0);
      wr(8'h0C, v);
      rdc("count limit", 8'h0C, v);
    end
    v = $unsigned($random(seed)) % 6;
    wr(8'h08, v);
    wr(8'h08, 32'h0000_0006);
    rdc("class", 8'h08, v);
    wr(8'h10, 32'h0000_0E11);
    rdc("wait", 8'h10, 32'h0000_000A);
    // clock enable low: a write must not land
    @(posedge clk) ce <= 1'b0;
    wr(8'h10, 32'h0000_0005);
    ce <= 1'b1;
    rdc("wait frozen", 8'h10, 32'h0000_000A);
    wr(8'h18, 32'h0000_002E);
    wr(8'h1C, 32'h0000_0092);
    wr(8'h20, 32'h0000_0040);
    // start held since power-up; after a latched trip selection 1 must not rerun
    wr(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0003);
    trip_pulse(FLT_OTHER);
    clear_fault();
    rdc("stop select", 8'h00, 32'h0000_0001);
    chk("term idle", 3'h2, term_out);
    chk("mode held", PFRT_M_IDLE, freq.mode);
    @(posedge clk) fwd <= 1'b0;
    @(posedge clk) fwd <= 1'b1;
    waitc(3, 5);
    slow <= 1'b1;
    @(posedge clk) power_fail <= 1'b1;
    waitc(0, 5);
    chk("pf mode", PFRT_M_HOLD_BUS, freq.mode);
    @(posedge clk) power_fail <= 1'b0;
    #1 chk("term pf", 3'h1, term_out);
    repeat (60) @(posedge clk);
    #1 chk("pf stopped", 1'h1, pfd);
    chk("no rerun", 1'h0, freq.mode === PFRT_M_RUN);
    @(posedge clk) fwd <= 1'b0;
    waitc(1, 5);
    @(posedge clk) fwd <= 1'b1;
    waitc(3, 5);
    // selection 2: reaccelerate, then drop start mid-outage
    wr(8'h00, 32'h0000_0002);
    @(posedge clk) power_fail <= 1'b1;
    waitc(0, 5);
    @(posedge clk) power_fail <= 1'b0;
    waitc(3, 5);
    @(posedge clk) power_fail <= 1'b1;
    waitc(0, 5);
    @(posedge clk) fwd <= 1'b0;
    waitc(4, 5);
    @(posedge clk) power_fail <= 1'b0;
    repeat (60) @(posedge clk);
    power_fail <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("pf when stopped", 1'h0, pfd);
    @(posedge clk) power_fail <= 1'b0;
    fwd <= 1'b1;
    waitc(3, 5);
    // auto restart replaces the stop selection
    wr(8'h04, 32'h0000_0005);
    wr(8'h00, 32'h0000_0001);
    @(posedge clk) power_fail <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("pf with restart", 1'h0, pfd);
    chk("coast mode", PFRT_M_COAST, freq.mode);
    @(posedge clk) power_fail <= 1'b0;
    waitc(2, 200);
    chk("auto restart", 1'h1, freq.auto_restart);
    wr(8'h04, 32'h0000_270F);
    wr(8'h00, 32'h0000_0000);
    slow <= 1'b0;
    // class table sweep over every fault code
    wr(8'h0C, 32'h0000_000A);
    wr(8'h10, 32'h0000_0001);
    for (i = 0; i < 6; i++) begin
      wr(8'h08, i);
      for (j = 0; j < 22; j++) begin
        trip_pulse(pfrt_fault_t'(j[4:0]));
        #1 chk("retried", picked(i, pfrt_fault_t'(j[4:0])), rty);
        chk("fault out", !picked(i, pfrt_fault_t'(j[4:0])), fault_out);
        clear_fault();
        waitc(3, 5);
        repeat (30) @(posedge clk); // success closes the watch
      end
    end
    wr(8'h0C, 32'h0000_0000);
    trip_pulse(FLT_OC_ACCEL);
    #1 chk("no retry", 1'h0, rty);
    clear_fault();
    waitc(3, 5);
    // full retry with shown fault output, then success counting
    wr(8'h0C, 32'h0000_0065);
    wr(8'h10, 32'h0000_0002);
    wr(8'h08, 32'h0000_0000);
    wr(8'h14, 32'h0000_0000);
    trip_pulse(FLT_OC_CONST);
    #1 chk("fault shown", 1'h1, fault_out);
    @(posedge clk);
    #1 chk("term retry", 1'h1, term_out[2]);
    waitc(2, 40);
    chk("retry wait", 1'h1, n >= 5 && n <= 9);
    repeat (45) @(posedge clk);
    rdc("success", 8'h14, 32'h0000_0001);
    wr(8'h14, 32'h0000_0005);
    rdc("success kept", 8'h14, 32'h0000_0001);
    wr(8'h14, 32'h0000_0000);
    rdc("success cleared", 8'h14, 32'h0000_0000);
    // consecutive failures beyond a limit of one
    wr(8'h0C, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001);
    trip_pulse(FLT_OC_ACCEL);
    waitc(2, 20);
    trip_pulse(FLT_OC_ACCEL);
    #1 chk("second retry", 1'h1, rty);
    waitc(2, 20);
    trip_pulse(FLT_OC_ACCEL);
    #1 chk("excess", 1'h1, exc);
    clear_fault();
    #1 chk("excess clear", 1'h0, exc);
    results();
  end
endmodule // testbench
